// file: logic/mbm_matrix.sv
// Three-master, four-slave AHB bus matrix with per-slave arbiters.
// Assumes APB setup/access protocol and AHB-lite masters and slaves.
//
// Contract
// - Three masters reach distinct slaves concurrently and independently.
// - Non-default master connects after one cycle; default master at once.
// - Each master has its own decoder; all share one address map.
// - Only the listed master-slave paths exist; others are unwired.
// - Every slave has its own arbiter and configuration.
// - Boot region maps to ROM or flash by configuration.
// - No default master: idle slave disconnects from all masters.
// - Last access master: idle slave stays with last requester.
// - Fixed default: idle slave joins configured master; software changes it.
// - Slave config holds 2-bit default kind and 4-bit fixed index.
// - Arbitration kind selects round-robin or priority; round-robin after reset.
// - Ownership changes only when idle, single, burst end, or slot expired.
// - Open bursts split every beat, at 4, 8, 16 beats or never, per master.
// - Slot counter loads at burst start, counts down; zero allows break.
// - Round-robin serves lowest master first, then rotates.
// - Round-robin without default adds one cycle to each first access.
// - Privileged default master sees no latency; others one cycle.
// - Fixed default master requests are granted without added latency.
// - Priority: highest value wins; ties go to highest master index.
// - Each slave holds a programmable priority per master.
// - Split codes: 0 never, 1 every beat, 2/3/4 four/eight/sixteen.
// - Default kind codes: 0 none, 1 last, 2 fixed.
// - Fixed index not wired to the slave acts as no default.
`timescale 1ns/10ps
`default_nettype none
`include "mbm_defs.svh"
module mbm_matrix
    import mbm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    input wire mbm_mreq_s m_req [`MBM_NM],
    output var mbm_mrsp_s m_rsp [`MBM_NM],
    output var mbm_sreq_s s_req [`MBM_NS],
    input wire mbm_srsp_s s_rsp [`MBM_NS]
);
    // ==========================================================
    // Helpers
    function automatic logic [3:0] wired(input logic [3:0] m);
        case (m)
            4'h0: wired = `MBM_WIRED_M0;
            4'h1: wired = `MBM_WIRED_M1;
            4'h2: wired = `MBM_WIRED_M2;
            default: wired = 4'h0;
        endcase
    endfunction

    // Same map for every master port
    function automatic logic [3:0] decode(input logic [31:0] a,
                                          input logic bf);
        logic [3:0] hit;
        hit = 4'h0;
        case (a[31:24])
            `MBM_RG_BOOT: hit[bf ? `MBM_S_FLASH : `MBM_S_ROM] = 1'b1;
            `MBM_RG_ROM: hit[`MBM_S_ROM] = 1'b1;
            `MBM_RG_FLASH: hit[`MBM_S_FLASH] = 1'b1;
            `MBM_RG_SRAM: hit[`MBM_S_SRAM] = 1'b1;
            `MBM_RG_BRIDGE: hit[`MBM_S_BRIDGE] = 1'b1;
            default: hit = 4'h0;
        endcase
        decode = hit;
    endfunction

    function automatic logic [4:0] blen_of(input logic [2:0] hb,
                                           input logic [2:0] ul);
        if (hb == `MBM_HB_INCR) begin
            case (ul)
                `MBM_OPEN_BURST_SPLIT_ONE: blen_of = 5'h01;
                `MBM_OPEN_BURST_SPLIT_4: blen_of = 5'h04;
                `MBM_OPEN_BURST_SPLIT_8: blen_of = 5'h08;
                `MBM_OPEN_BURST_SPLIT_16: blen_of = 5'h10;
                default: blen_of = 5'h00;
            endcase
        end else if (hb == `MBM_HB_SINGLE) begin
            blen_of = 5'h01;
        end else begin
            blen_of = 5'(5'h02 << hb[2:1]);
        end
    endfunction

    function automatic logic [1:0] prio_of(input logic [31:0] p,
                                           input int m);
        prio_of = p[m*`MBM_PRIO_STEP +: 2];
    endfunction

    function automatic logic [1:0] pick(input logic [2:0] c,
                                        input logic [1:0] arb,
                                        input logic [31:0] p,
                                        input logic [1:0] last);
        logic [1:0] w;
        logic [1:0] best;
        logic [1:0] idx;
        logic found;
        w = 2'h0;
        best = 2'h0;
        found = 1'b0;
        if (arb == MBM_ARB_PRIO) begin
            for (int m = 0; m < `MBM_NM; m++) begin
                if (c[m] && (!found || prio_of(p, m) >= best)) begin
                    w = 2'(m);
                    best = prio_of(p, m);
                    found = 1'b1;
                end
            end
        end else begin
            for (int k = 1; k <= `MBM_NM; k++) begin
                idx = 2'((int'(last) + k) % `MBM_NM);
                if (c[idx] && !found) begin
                    w = idx;
                    found = 1'b1;
                end
            end
        end
        pick = w;
    endfunction

    function automatic logic [1:0] idx_of(input logic [3:0] oh);
        idx_of = 2'h0;
        for (int s = 0; s < `MBM_NS; s++) begin
            if (oh[s]) begin
                idx_of = 2'(s);
            end
        end
    endfunction

    // ==========================================================
    // Configuration registers
    logic [2:0] open_burst_split [`MBM_NM];
    logic [31:0] scfg [`MBM_NS];
    logic [31:0] prio [`MBM_NS];
    logic boot_flash;
    logic own_v [`MBM_NS];
    logic [1:0] own [`MBM_NS];
    logic wr;
    logic mapped;
    logic [31:0] rd_val;

    assign wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    always_comb begin
        mapped = 1'b0;
        rd_val = 32'h0;
        for (int m = 0; m < `MBM_NM; m++) begin
            if (paddr == `MBM_OFS_MCFG + 12'(m) * `MBM_STEP_MCFG) begin
                mapped = 1'b1;
                rd_val = {29'h0, open_burst_split[m]};
            end
        end
        for (int s = 0; s < `MBM_NS; s++) begin
            if (paddr == `MBM_OFS_SCFG + 12'(s) * `MBM_STEP_SCFG) begin
                mapped = 1'b1;
                rd_val = scfg[s];
            end
            if (paddr == `MBM_OFS_PRIO + 12'(s) * `MBM_STEP_PRIO) begin
                mapped = 1'b1;
                rd_val = prio[s];
            end
        end
        if (paddr == `MBM_OFS_BOOT) begin
            mapped = 1'b1;
            rd_val = {31'h0, boot_flash};
        end
        if (paddr == `MBM_OFS_OWNER) begin
            mapped = 1'b1;
            for (int s = 0; s < `MBM_NS; s++) begin
                rd_val[s*4 +: 3] = {own_v[s], own[s]};
            end
        end
    end

    // Read data captured in the setup cycle, valid in the access phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            prdata <= rd_val;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int m = 0; m < `MBM_NM; m++) begin
                open_burst_split[m] <= `MBM_OPEN_BURST_SPLIT_INF;
            end
            scfg[0] <= `MBM_SCFG_RST0;
            scfg[1] <= `MBM_SCFG_RST1;
            scfg[2] <= `MBM_SCFG_RST2;
            scfg[3] <= `MBM_SCFG_RST3;
            for (int s = 0; s < `MBM_NS; s++) begin
                prio[s] <= 32'h0;
            end
            boot_flash <= 1'b0;
        end else if (wr && mapped) begin
            for (int m = 0; m < `MBM_NM; m++) begin
                if (paddr == `MBM_OFS_MCFG + 12'(m) * `MBM_STEP_MCFG) begin
                    open_burst_split[m] <= pwdata[`MBM_F_OPEN_BURST_SPLIT];
                end
            end
            for (int s = 0; s < `MBM_NS; s++) begin
                if (paddr == `MBM_OFS_SCFG + 12'(s) * `MBM_STEP_SCFG) begin
                    scfg[s] <= 32'h0;
                    scfg[s][`MBM_F_SLOT] <= pwdata[`MBM_F_SLOT];
                    scfg[s][`MBM_F_KIND] <= pwdata[`MBM_F_KIND];
                    scfg[s][`MBM_F_FIXED] <= pwdata[`MBM_F_FIXED];
                    scfg[s][`MBM_F_ARB] <= pwdata[`MBM_F_ARB];
                end
                if (paddr == `MBM_OFS_PRIO + 12'(s) * `MBM_STEP_PRIO) begin
                    prio[s] <= pwdata & 32'h00000333;
                end
            end
            if (paddr == `MBM_OFS_BOOT) begin
                boot_flash <= pwdata[0];
            end
        end
    end

    // ==========================================================
    // Master side: decode and data-phase tracking
    logic [3:0] tgt [`MBM_NM];
    logic [1:0] tix [`MBM_NM];
    logic areq [`MBM_NM];
    logic mfree [`MBM_NM];
    logic gnt [`MBM_NM];
    logic hready_m [`MBM_NM];
    logic dph_v [`MBM_NM];
    logic dph_done [`MBM_NM];
    logic [1:0] dph_s [`MBM_NM];
    logic [31:0] lat_rdata [`MBM_NM];
    logic lat_resp [`MBM_NM];
    logic [2:0] req [`MBM_NS];

    always_comb begin
        for (int s = 0; s < `MBM_NS; s++) begin
            req[s] = 3'h0;
        end
        for (int m = 0; m < `MBM_NM; m++) begin
            tgt[m] = decode(m_req[m].haddr, boot_flash)
                & wired(4'(m));
            tix[m] = idx_of(tgt[m]);
            areq[m] = (m_req[m].htrans != `MBM_TR_IDLE) && (tgt[m] != 4'h0);
            mfree[m] = !dph_v[m] || dph_done[m]
                || s_rsp[dph_s[m]].hreadyout;
            gnt[m] = areq[m] && own_v[tix[m]] && (own[tix[m]] == 2'(m));
            // Unmapped or unwired requests are swallowed with OKAY
            hready_m[m] = mfree[m] && (!areq[m]
                || (gnt[m] && s_rsp[tix[m]].hreadyout));
            for (int s = 0; s < `MBM_NS; s++) begin
                req[s][m] = areq[m] && tgt[m][s];
            end
            m_rsp[m].hready = hready_m[m];
            m_rsp[m].hresp = dph_done[m] ? lat_resp[m]
                : (dph_v[m] && s_rsp[dph_s[m]].hresp);
            m_rsp[m].hrdata = dph_done[m] ? lat_rdata[m]
                : (dph_v[m] ? s_rsp[dph_s[m]].hrdata : 32'h0);
        end
    end

    // A finished data phase is held while the next address waits
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int m = 0; m < `MBM_NM; m++) begin
                dph_v[m] <= 1'b0;
                dph_done[m] <= 1'b0;
                dph_s[m] <= 2'h0;
                lat_rdata[m] <= 32'h0;
                lat_resp[m] <= 1'b0;
            end
        end else begin
            for (int m = 0; m < `MBM_NM; m++) begin
                if (hready_m[m]) begin
                    dph_v[m] <= areq[m] && m_req[m].htrans[1];
                    dph_s[m] <= tix[m];
                    dph_done[m] <= 1'b0;
                end else if (dph_v[m] && !dph_done[m]
                             && s_rsp[dph_s[m]].hreadyout) begin
                    dph_done[m] <= 1'b1;
                    lat_rdata[m] <= s_rsp[dph_s[m]].hrdata;
                    lat_resp[m] <= s_rsp[dph_s[m]].hresp;
                end
            end
        end
    end

    // ==========================================================
    // Slave side: one arbiter per slave
    logic [1:0] rr_last [`MBM_NS];
    logic [4:0] beat [`MBM_NS];
    logic [4:0] blen [`MBM_NS];
    logic [7:0] slot [`MBM_NS];
    logic busy [`MBM_NS];
    logic acc [`MBM_NS];
    logic last_beat [`MBM_NS];
    logic rearb [`MBM_NS];
    logic [2:0] cand [`MBM_NS];
    logic [4:0] blen_now [`MBM_NS];
    logic [4:0] beat_n [`MBM_NS];
    logic fix_ok [`MBM_NS];

    always_comb begin
        for (int s = 0; s < `MBM_NS; s++) begin
            busy[s] = own_v[s] && req[s][own[s]];
            s_req[s].cmd = m_req[own[s]];
            s_req[s].hsel = busy[s] && mfree[own[s]];
            s_req[s].hready = s_rsp[s].hreadyout;
            acc[s] = s_req[s].hsel && s_rsp[s].hreadyout
                && m_req[own[s]].htrans[1];
            blen_now[s] = (m_req[own[s]].htrans == `MBM_TR_NONSEQ)
                ? blen_of(m_req[own[s]].hburst, open_burst_split[own[s]]) : blen[s];
            beat_n[s] = (m_req[own[s]].htrans == `MBM_TR_NONSEQ)
                ? 5'h01 : 5'(beat[s] + 5'h01);
            last_beat[s] = (blen_now[s] != 5'h00) && (beat_n[s] == blen_now[s]);
            // Break points only; a burst in flight keeps its slave
            rearb[s] = !busy[s]
                || (acc[s] && (last_beat[s] || slot[s] == 8'h00));
            cand[s] = req[s] & ~(acc[s] ? 3'(3'h1 << own[s]) : 3'h0);
            fix_ok[s] = (scfg[s][`MBM_F_FIXED] < 4'(`MBM_NM))
                && ((wired(scfg[s][`MBM_F_FIXED]) & 4'(1 << s)) != 4'h0);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < `MBM_NS; s++) begin
                own_v[s] <= 1'b0;
                own[s] <= 2'h0;
                rr_last[s] <= 2'h2;
            end
        end else begin
            for (int s = 0; s < `MBM_NS; s++) begin
                if (rearb[s] && cand[s] != 3'h0) begin
                    own_v[s] <= 1'b1;
                    own[s] <= pick(cand[s], scfg[s][`MBM_F_ARB],
                        prio[s], rr_last[s]);
                    rr_last[s] <= pick(cand[s], scfg[s][`MBM_F_ARB],
                        prio[s], rr_last[s]);
                end else if (rearb[s]) begin
                    case (scfg[s][`MBM_F_KIND])
                        MBM_DM_LAST: own_v[s] <= own_v[s];
                        MBM_DM_FIXED: begin
                            own_v[s] <= fix_ok[s];
                            own[s] <= 2'(scfg[s][`MBM_F_FIXED]);
                        end
                        default: own_v[s] <= 1'b0;
                    endcase
                end
            end
        end
    end

    // Beat and slot counters restart at each burst start
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int s = 0; s < `MBM_NS; s++) begin
                beat[s] <= 5'h00;
                blen[s] <= 5'h00;
                slot[s] <= 8'h00;
            end
        end else begin
            for (int s = 0; s < `MBM_NS; s++) begin
                if (acc[s]) begin
                    beat[s] <= last_beat[s] ? 5'h00 : beat_n[s];
                    blen[s] <= blen_now[s];
                end
                if (acc[s] && m_req[own[s]].htrans == `MBM_TR_NONSEQ) begin
                    slot[s] <= scfg[s][`MBM_F_SLOT];
                end else if (slot[s] != 8'h00) begin
                    slot[s] <= slot[s] - 8'h01;
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence idle_ask(int s);
        !busy[s] && cand[s] != 3'h0;
    endsequence

    for (genvar gs = 0; gs < `MBM_NS; gs++) begin : g_chk
        path_wired_a: assert property (own_v[gs] |->
            (wired(4'(own[gs])) & 4'(1 << gs)) != 4'h0)
            else $error("owner not wired to slave");
        sel_owner_a: assert property (s_req[gs].hsel |-> req[gs][own[gs]])
            else $error("slave selected without owner request");
        connect_one_a: assert property (idle_ask(gs) |=> own_v[gs])
            else $error("idle request not connected next cycle");
        no_default_a: assert property (rearb[gs] && cand[gs] == 3'h0
            && scfg[gs][`MBM_F_KIND] == MBM_DM_NONE |=> !own_v[gs])
            else $error("slave kept an owner with no default");
        last_keep_a: assert property (rearb[gs] && cand[gs] == 3'h0
            && own_v[gs] && scfg[gs][`MBM_F_KIND] == MBM_DM_LAST
            |=> own_v[gs] && own[gs] == $past(own[gs]))
            else $error("last access master dropped");
        fixed_owner_a: assert property (rearb[gs] && cand[gs] == 3'h0
            && scfg[gs][`MBM_F_KIND] == MBM_DM_FIXED
            |=> own_v[gs] == $past(fix_ok[gs]))
            else $error("fixed default master not applied");
        burst_hold_a: assert property (busy[gs] && !rearb[gs]
            |=> own_v[gs] && own[gs] == $past(own[gs]))
            else $error("owner changed inside a burst");
        rr_first_a: assert property (rearb[gs] && cand[gs] == 3'h7
            && rr_last[gs] == 2'h2 && scfg[gs][`MBM_F_ARB] == MBM_ARB_RR
            |=> own[gs] == 2'h0)
            else $error("round-robin did not start at master 0");
        prio_tie_a: assert property (rearb[gs] && cand[gs] == 3'h7
            && prio[gs] == 32'h0 && scfg[gs][`MBM_F_ARB] == MBM_ARB_PRIO
            |=> own[gs] == 2'h2)
            else $error("priority tie not won by highest index");
    end
endmodule
`default_nettype wire

// file: logic/mbm_defs.svh
// Constants of the three-by-four bus matrix: map, wiring, registers.
// Assumes inclusion by bare name from the matrix and the bench.
`ifndef MBM_DEFS_SVH
`define MBM_DEFS_SVH
`define MBM_NM 3
`define MBM_NS 4
// Slave order: 0 SRAM, 1 ROM, 2 flash, 3 bridge
`define MBM_WIRED_M0 4'b0110
`define MBM_WIRED_M1 4'b1001
`define MBM_WIRED_M2 4'b1011
`define MBM_S_SRAM 2'h0
`define MBM_S_ROM 2'h1
`define MBM_S_FLASH 2'h2
`define MBM_S_BRIDGE 2'h3
`define MBM_RG_BOOT 8'h00
`define MBM_RG_ROM 8'h01
`define MBM_RG_FLASH 8'h04
`define MBM_RG_SRAM 8'h20
`define MBM_RG_BRIDGE 8'h40
`define MBM_OFS_MCFG 12'h000
`define MBM_OFS_SCFG 12'h040
`define MBM_OFS_PRIO 12'h080
`define MBM_OFS_BOOT 12'h100
`define MBM_OFS_OWNER 12'h104
`define MBM_STEP_MCFG 12'h004
`define MBM_STEP_SCFG 12'h004
`define MBM_STEP_PRIO 12'h008
`define MBM_SCFG_RST0 32'h00010010
`define MBM_SCFG_RST1 32'h00050010
`define MBM_SCFG_RST2 32'h00000010
`define MBM_SCFG_RST3 32'h00000010
`define MBM_F_OPEN_BURST_SPLIT 2:0
`define MBM_F_SLOT 7:0
`define MBM_F_KIND 17:16
`define MBM_F_FIXED 21:18
`define MBM_F_ARB 25:24
`define MBM_PRIO_STEP 4
`define MBM_OPEN_BURST_SPLIT_INF 3'h0
`define MBM_OPEN_BURST_SPLIT_ONE 3'h1
`define MBM_OPEN_BURST_SPLIT_4 3'h2
`define MBM_OPEN_BURST_SPLIT_8 3'h3
`define MBM_OPEN_BURST_SPLIT_16 3'h4
`define MBM_TR_IDLE 2'h0
`define MBM_TR_NONSEQ 2'h2
`define MBM_HB_SINGLE 3'h0
`define MBM_HB_INCR 3'h1
`endif

// file: logic/mbm_pkg.sv
// Types shared by the bus matrix and its surroundings.
// Assumes AHB-style masters and slaves on one clock.
`default_nettype none
package mbm_pkg;
    typedef enum logic [1:0] {
        MBM_DM_NONE = 2'b00,
        MBM_DM_LAST = 2'b01,
        MBM_DM_FIXED = 2'b10
    } mbm_dm_e;
    typedef enum logic [1:0] {
        MBM_ARB_RR = 2'b00,
        MBM_ARB_PRIO = 2'b01
    } mbm_arb_e;
    typedef struct packed {
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [2:0] hburst;
        logic [31:0] hwdata;
    } mbm_mreq_s;
    typedef struct packed {
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
    } mbm_mrsp_s;
    typedef struct packed {
        logic hsel;
        logic hready;
        mbm_mreq_s cmd;
    } mbm_sreq_s;
    typedef struct packed {
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
    } mbm_srsp_s;
endpackage
`default_nettype wire

// file: testbench/mbm_slave_model.sv
// Behavioural AHB memory slave standing behind one matrix slave port.
// Assumes the matrix drives hready back equal to this slave's hreadyout.
`timescale 1ns/10ps
`default_nettype none
module mbm_slave_model
    import mbm_pkg::*;
#(
    parameter logic [1:0] IDX = 2'h0,
    parameter int WAIT = 0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire mbm_sreq_s req,
    output var mbm_srsp_s rsp
);
    logic act;
    logic [31:0] q;
    int cnt;
    // ==========================================
    // Data phase, optionally stretched by wait states
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            act <= 1'b0;
            q <= 32'h0;
            cnt <= 0;
        end else if (rsp.hreadyout) begin
            act <= req.hsel && req.hready && req.cmd.htrans[1];
            q <= {6'h2a, IDX, req.cmd.haddr[23:0]};
            cnt <= WAIT;
        end else begin
            cnt <= cnt - 1;
        end
    end
    // Outside a valid data phase the bus shows garbage, never stale data
    always_comb begin
        rsp.hreadyout = !act || cnt == 0;
        rsp.hresp = 1'b0;
        rsp.hrdata = (act && cnt == 0) ? q : ~q;
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the bus matrix: APB set-up, AHB masters, slave models.
// Assumes one 40 MHz clock and slaves answering through mbm_slave_model.
`timescale 1ns/10ps
`default_nettype none
`include "mbm_defs.svh"
module tb_top
    import mbm_pkg::*;
;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    mbm_mreq_s m_req [`MBM_NM];
    mbm_mrsp_s m_rsp [`MBM_NM];
    mbm_sreq_s s_req [`MBM_NS];
    mbm_srsp_s s_rsp [`MBM_NS];
    int num_errors = 0;
    int tests_run = 0;
    logic [31:0] scfg_rst [4] = '{32'h00010010, 32'h00050010, 32'h00000010, 32'h00000010};
    logic [7:0] rgn [4] = '{8'h20, 8'h01, 8'h04, 8'h40};
    logic [3:0] wired [3] = '{4'b0110, 4'b1001, 4'b1011};

    mbm_matrix dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .m_req(m_req), .m_rsp(m_rsp), .s_req(s_req), .s_rsp(s_rsp));
    // SRAM model is slow so data phases overlap arbitration
    for (genvar i = 0; i < 4; i++) begin : g_slv
        mbm_slave_model #(.IDX(2'(i)), .WAIT(i == 0 ? 2 : 0)) u_slv (.ref_clk(ref_clk),
            .nrst(nrst), .req(s_req[i]), .rsp(s_rsp[i]));
    end

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // ==========================================
    // Checking and closing
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_int(input int got, input int exp);
        chk32(32'(got), 32'(exp));
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ==========================================
    // Bus tasks
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // Single read; hready is sampled at the falling edge, where it has settled
    task automatic ahb(input int m, input logic [31:0] a, output logic [31:0] r,
        output int lat);
        lat = 0;
        @(posedge ref_clk);
        m_req[m].haddr <= a;
        m_req[m].htrans <= `MBM_TR_NONSEQ;
        @(negedge ref_clk);
        while (m_rsp[m].hready !== 1'b1) begin
            lat++;
            @(negedge ref_clk);
        end
        @(posedge ref_clk);
        m_req[m].htrans <= `MBM_TR_IDLE;
        @(negedge ref_clk);
        while (m_rsp[m].hready !== 1'b1) @(negedge ref_clk);
        r = m_rsp[m].hrdata;
        @(posedge ref_clk);
    endtask
    task automatic lat_is(input int m, input logic [31:0] a, input int exp);
        logic [31:0] r;
        int l;
        ahb(m, a, r, l);
        chk_int(l, exp);
    endtask
    task automatic race(output int l1, output int l2);
        logic [31:0] r1;
        logic [31:0] r2;
        fork
            ahb(1, 32'h20000100, r1, l1);
            ahb(2, 32'h20000200, r2, l2);
        join
    endtask
    function automatic logic [31:0] pat(input logic [1:0] s, input logic [31:0] a);
        return {6'h2a, s, a[23:0]};
    endfunction
    // ==========================================
    // Tests
    initial begin
        logic [31:0] r;
        logic [31:0] a;
        logic e;
        int l1;
        int l2;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        for (int i = 0; i < 3; i++) begin
            m_req[i] = '0;
            m_req[i].hsize = 3'h2;
        end
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            apb(1'b0, 12'h040 + 12'(4 * s), 32'h0, r, e);
            chk32(r, scfg_rst[s]);
        end
        apb(1'b0, 12'h080, 32'h0, r, e);
        chk32(r, 32'h0);
        wr(12'h004, 32'h4);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk32(r, 32'h4);
        apb(1'b0, 12'h00c, 32'h0, r, e);
        chk32({31'h0, e}, 32'h1);
        for (int m = 0; m < 3; m++) begin
            for (int s = 0; s < 4; s++) begin
                a = {rgn[s], 16'h0, 8'(4 * m)};
                ahb(m, a, r, l1);
                chk32(r, wired[m][s] ? pat(2'(s), a) : 32'h0);
            end
        end
        lat_is(0, 32'h04000040, 1);
        lat_is(0, 32'h04000044, 1);
        lat_is(2, 32'h01000040, 0);
        lat_is(0, 32'h01000044, 1);
        lat_is(0, 32'h01000048, 0);
        wr(12'h04c, 32'h000a0010);
        @(posedge ref_clk);
        lat_is(2, 32'h40000010, 0);
        lat_is(1, 32'h40000014, 1);
        lat_is(2, 32'h40000018, 0);
        wr(12'h04c, 32'h00020010);
        lat_is(1, 32'h4000001c, 1);
        lat_is(1, 32'h40000020, 1);
        ahb(0, 32'h00000020, r, l1);
        chk32(r, pat(2'h1, 32'h00000020));
        wr(12'h100, 32'h1);
        ahb(0, 32'h00000020, r, l1);
        chk32(r, pat(2'h2, 32'h00000020));
        wr(12'h040, 32'h00000010);
        race(l1, l2);
        chk_int(l1, 1);
        chk_int(int'(l2 > 1), 1);
        wr(12'h040, 32'h01000010);
        wr(12'h080, 32'h00000210);
        race(l1, l2);
        chk_int(l2, 1);
        wr(12'h080, 32'h00000110);
        race(l1, l2);
        chk_int(l2, 1);
        summarize();
    end
    // A hung handshake is cut short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
